//--- design/fss_defs.svh
`ifndef FSS_DEFS_SVH
`define FSS_DEFS_SVH

// register sub-addresses
`define FSS_ADDR_FWSTAT 8'h02
`define FSS_ADDR_OUTPUT_ENABLE_REG 8'h10
`define FSS_ADDR_SYSTEM_CONTROL_TWO 8'h12
`define FSS_ADDR_RAIL_GOOD_STATUS 8'h13
`define FSS_ADDR_CLRIRQ 8'h1F
`define FSS_ADDR_TGT0 8'h20
`define FSS_ADDR_TGT1 8'h22
`define FSS_ADDR_TGT2 8'h24
`define FSS_ADDR_TGT3 8'h26

// field positions
`define FSS_OUTPUT_ENABLE_REG_SW_BIT 7
`define FSS_SYSTEM_CONTROL_TWO_PGMASK_BIT 7
`define FSS_TGT_KEEP_BIT 6
`define FSS_TGT_SLEWOK_BIT 5
`define FSS_FW_PGTO_BIT 3
`define FSS_FW_UVW_BIT 4
`define FSS_FW_UVF_BIT 5
`define FSS_FW_THW_BIT 6
`define FSS_FW_THF_BIT 7

// reset values
`define FSS_RST_CMD 8'h00

// timing, figures in microseconds, counts in cycles of the 20 MHz clock
`define FSS_CLK_MHZ 20
`define FSS_T_DEB_US 25
`define FSS_T_PGD_US 250
`define FSS_T_TO_US 14000
`define FSS_T_INH_US 1000000
`define FSS_DEB_CYC (`FSS_T_DEB_US * `FSS_CLK_MHZ)
`define FSS_PGD_CYC (`FSS_T_PGD_US * `FSS_CLK_MHZ)
`define FSS_TO_CYC (`FSS_T_TO_US * `FSS_CLK_MHZ)
`define FSS_INH_CYC (`FSS_T_INH_US * `FSS_CLK_MHZ)

`endif

//--- design/fss_pkg.sv
package fss_pkg;
    typedef logic [24:0] fss_cnt_t;
    typedef logic [7:0] fss_byte_t;
    typedef enum logic [1:0] {
        FSS_ST_START,
        FSS_ST_RUN,
        FSS_ST_PDN
    } fss_state_t;
endpackage

//--- design/fss_sync.sv
`timescale 1ns/1ps
module fss_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule

//--- design/fss_supervisor.sv
// Overview of operation
// - keep-alive bit set keeps its regulator on in standby regardless of request and wake.
// - kept-alive regulator stays on until bit cleared, hard reset, or any fault.
// - software-control bit set makes regulators follow only their enable register bits and keep-alive bits.
// - falling power-on request clears the whole output enable register.
// - fault on input undervoltage, over-temperature, or rail low for 14 ms.
// - reset output low at start until always-on rail good and start timer done.
// - reset output low when always-on rail lost over 25 us, or hard reset.
// - reset output released 14 ms after always-on rail is good again.
// - undervoltage at end of start-up time sets status bit and interrupt.
// - enabled rail low over 25 us drops rail-ok output and its status bit.
// - status bit 0 always-on, 1-3 step-down, 4 buck-boost, 5-7 linear.
// - no regulator enabled means rail-ok low and all rail status zero.
// - rail-ok rises 250 us after last rail good; lows last event plus 250 us.
// - rail-ok low over 14 ms is a timeout fault unless masked by control bit 7.
// - slew drops rail-ok unless target bit 5 set; rail status unaffected.
// - input undervoltage warning sets status bit 4 and interrupt.
// - thermal warning sets bit 6 and interrupt; thermal fault starts shutdown.
// - status bits 3 timeout, 4 uv warn, 5 uv fault, 6 th warn, 7 th fault.
// - warning holds interrupt and bit until clear command and condition gone.
// - fault interrupt held until clear; bit then held for inhibit time or fault.
// - fault sets bit, drops interrupt and wake, disables all, clears enables, powers down.
// - re-enable waits for fault gone and one second; then wake follows request.
// - clear-interrupt command acts at sub-address acknowledge; its data ignored.
// - fault shutdown leaves interrupt and status registers untouched.
`timescale 1ns/1ps
`include "fss_defs.svh"
module fss_supervisor import fss_pkg::*; #(
    parameter int P_PGD_CYC = `FSS_PGD_CYC,
    parameter int P_TO_CYC = `FSS_TO_CYC,
    parameter int P_INH_CYC = `FSS_INH_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port from the serial interface
    input wire logic reg_wr_i,
    input wire logic reg_sub_ack_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // pins and pushbutton controller
    input wire logic power_on_request_i,
    input wire logic [6:0] en_pin_i,
    input wire logic hard_reset_i,
    // analog monitors
    input wire logic [7:0] rail_good_raw_i,
    input wire logic [3:0] slew_active_i,
    input wire logic vin_warn_i,
    input wire logic vin_fault_i,
    input wire logic temp_warn_i,
    input wire logic temp_fault_i,
    // outputs
    output logic [6:0] reg_en_o,
    output logic wake_o,
    output logic irq_n_o,
    output logic rail_ok_output_o,
    output logic reset_output_n_o,
    output logic powerdown_state_o
);
    localparam fss_cnt_t L_DEB = fss_cnt_t'(`FSS_DEB_CYC);
    localparam fss_cnt_t L_PGD = fss_cnt_t'(P_PGD_CYC);
    localparam fss_cnt_t L_TO = fss_cnt_t'(P_TO_CYC);
    localparam fss_cnt_t L_INH = fss_cnt_t'(P_INH_CYC);

    logic [23:0] sync_w;
    logic po_s, uvw_s, uvf_s, thw_s, thf_s;
    logic [6:0] en_pin_s;
    logic [7:0] raw_s;
    logic [3:0] slew_s;

    fss_sync #(.W(24)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({power_on_request_i, en_pin_i, rail_good_raw_i, slew_active_i,
              vin_warn_i, vin_fault_i, temp_warn_i, temp_fault_i}),
        .q_o(sync_w)
    );
    assign {po_s, en_pin_s, raw_s, slew_s, uvw_s, uvf_s, thw_s, thf_s} = sync_w;

    fss_state_t st_q, st_d;
    fss_cnt_t tmr_q, pg_cnt_q, rst_cnt_q;
    fss_byte_t output_enable_reg_q, system_control_two_q, fws_q, fws_d, rdata_q;
    fss_byte_t tgt_q [4];
    logic [7:0] good_q;
    logic [6:0] en_q, en_d, ka_map;
    logic hr_q, po_q, clr_pend_q, fault_irq_q;
    logic wake_q, irq_n_q, rail_ok_q, rst_n_q, pdn_q;

    // rail debouncers: low after 25 us, good after 250 us of steady good
    fss_cnt_t deb_q [8];
    for (genvar k = 0; k < 8; k++) begin : g_rail
        wire deb_done = good_q[k] ? (deb_q[k] == L_DEB - 1) : (deb_q[k] == L_PGD - 1);
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                deb_q[k] <= '0;
                good_q[k] <= 1'b0;
            end else if (good_q[k] == raw_s[k]) begin
                deb_q[k] <= '0;
            end else if (deb_done) begin
                deb_q[k] <= '0;
                good_q[k] <= ~good_q[k];
            end else begin
                deb_q[k] <= deb_q[k] + 1'b1;
            end
        end
    end

    // decode
    wire run_w = (st_q == FSS_ST_RUN);
    wire any_en = |en_q;
    wire [7:0] rail_en = {en_q, 1'b1};
    wire [7:0] rail_good_status_w = any_en ? (good_q & rail_en) : 8'h00;
    wire [3:0] slew_ok = {tgt_q[3][`FSS_TGT_SLEWOK_BIT], tgt_q[2][`FSS_TGT_SLEWOK_BIT],
                          tgt_q[1][`FSS_TGT_SLEWOK_BIT], tgt_q[0][`FSS_TGT_SLEWOK_BIT]};
    wire slew_low = |(slew_s & ~slew_ok);
    wire pg_ok_d = any_en && ((good_q | ~rail_en) == 8'hFF) && !slew_low;
    wire pg_counting = run_w && any_en && !rail_ok_q;
    wire pg_to_w = pg_counting && (pg_cnt_q == L_TO - 1);
    wire hr_evt = hard_reset_i;
    wire fault_evt = run_w && (uvf_s || thf_s || (pg_to_w && !system_control_two_q[`FSS_SYSTEM_CONTROL_TWO_PGMASK_BIT]));
    wire fault_hold = uvf_s || thf_s;
    wire inhibit = !run_w || fault_evt || hr_evt;
    wire start_end = (st_q == FSS_ST_START) && (tmr_q == L_INH - 1);
    wire start_uv = start_end && (uvw_s || uvf_s);
    wire clr_cmd = reg_sub_ack_i && (reg_addr_i == `FSS_ADDR_CLRIRQ);
    wire wr_output_enable_reg = reg_wr_i && (reg_addr_i == `FSS_ADDR_OUTPUT_ENABLE_REG);
    wire wr_system_control_two = reg_wr_i && (reg_addr_i == `FSS_ADDR_SYSTEM_CONTROL_TWO);
    wire cmd_clear = fault_evt || hr_evt;
    wire po_fall = po_q && !po_s;
    wire sensed = (st_q != FSS_ST_START) || start_end;

    assign ka_map = {2'b00, tgt_q[3][`FSS_TGT_KEEP_BIT], 1'b0, tgt_q[2][`FSS_TGT_KEEP_BIT],
                     tgt_q[1][`FSS_TGT_KEEP_BIT], tgt_q[0][`FSS_TGT_KEEP_BIT]};

    // supervisory state: start-up and fault power-down share one timer
    always_comb begin
        st_d = st_q;
        case (st_q)
            FSS_ST_START: if (start_end) st_d = FSS_ST_RUN;
            FSS_ST_RUN: if (fault_evt) st_d = FSS_ST_PDN;
            FSS_ST_PDN: if (tmr_q >= L_INH - 1 && !fault_hold && !hr_evt) st_d = FSS_ST_RUN;
            default: st_d = FSS_ST_PDN;
        endcase
        if (hr_evt) begin
            st_d = FSS_ST_PDN;
        end
    end

    // set wins over clear; fault bits also hold through power-down
    wire [7:0] fw_set = {thf_s & sensed, thw_s & sensed, uvf_s & sensed, uvw_s & sensed, pg_to_w, 3'b000};
    wire [7:0] fw_hold = {thf_s | !run_w, thw_s, uvf_s | !run_w, uvw_s, !run_w, 3'b000};
    // a masked rail timeout still pulls the interrupt low, it only skips the shutdown
    wire fault_irq_d = (fault_irq_q && !clr_cmd) || fault_evt || start_uv || pg_to_w;
    wire clr_pend_d = (clr_pend_q || clr_cmd) && (fws_d != 8'h00);

    always_comb begin
        fws_d = (fws_q & ~({8{clr_pend_q}} & ~fw_hold)) | fw_set;
        fws_d[2:0] = 3'b000;
    end

    // software control ignores pins; keep-alive ORs in regardless of wake
    always_comb begin
        if (inhibit) begin
            en_d = 7'h00;
        end else if (output_enable_reg_q[`FSS_OUTPUT_ENABLE_REG_SW_BIT]) begin
            en_d = output_enable_reg_q[6:0] | ka_map;
        end else begin
            en_d = output_enable_reg_q[6:0] | en_pin_s | ka_map;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= FSS_ST_START;
            tmr_q <= '0;
            hr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= (st_d != st_q || hr_evt) ? '0 : (tmr_q == L_INH ? tmr_q : tmr_q + 1'b1);
            hr_q <= hr_evt || (hr_q && st_d == FSS_ST_PDN);
        end
    end

    // command registers; shutdown events clear all, then request fall, then writes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_enable_reg_q <= `FSS_RST_CMD;
            system_control_two_q <= `FSS_RST_CMD;
            for (int i = 0; i < 4; i++) tgt_q[i] <= `FSS_RST_CMD;
        end else if (cmd_clear) begin
            output_enable_reg_q <= `FSS_RST_CMD;
            system_control_two_q <= `FSS_RST_CMD;
            for (int i = 0; i < 4; i++) tgt_q[i] <= `FSS_RST_CMD;
        end else begin
            if (po_fall) output_enable_reg_q <= `FSS_RST_CMD;
            else if (wr_output_enable_reg) output_enable_reg_q <= reg_wdata_i;
            if (wr_system_control_two) system_control_two_q <= reg_wdata_i;
            for (int i = 0; i < 4; i++) begin
                if (reg_wr_i && reg_addr_i == `FSS_ADDR_TGT0 + 8'(2 * i)) tgt_q[i] <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pg_cnt_q <= '0;
            rst_cnt_q <= '0;
        end else begin
            pg_cnt_q <= !pg_counting ? '0 : (pg_cnt_q == L_TO ? pg_cnt_q : pg_cnt_q + 1'b1);
            rst_cnt_q <= (!good_q[0] || hr_q) ? '0 : (rst_cnt_q == L_TO ? rst_cnt_q : rst_cnt_q + 1'b1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fws_q <= 8'h00;
            fault_irq_q <= 1'b0;
            clr_pend_q <= 1'b0;
            po_q <= 1'b0;
        end else begin
            fws_q <= fws_d;
            fault_irq_q <= fault_irq_d;
            clr_pend_q <= clr_pend_d;
            po_q <= po_s;
        end
    end

    // registered outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_q <= 7'h00;
            wake_q <= 1'b0;
            irq_n_q <= 1'b1;
            rail_ok_q <= 1'b0;
            rst_n_q <= 1'b0;
            pdn_q <= 1'b0;
        end else begin
            en_q <= en_d;
            wake_q <= !inhibit && po_s;
            irq_n_q <= !(fault_irq_d || fws_d[`FSS_FW_UVW_BIT] || fws_d[`FSS_FW_THW_BIT]);
            rail_ok_q <= pg_ok_d;
            rst_n_q <= st_d != FSS_ST_START && !hr_evt && !hr_q && good_q[0] && rst_cnt_q == L_TO;
            pdn_q <= (st_d == FSS_ST_PDN);
        end
    end

    // one-cycle read latency; unmapped addresses read zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else begin
            case (reg_addr_i)
                `FSS_ADDR_FWSTAT: rdata_q <= fws_q;
                `FSS_ADDR_RAIL_GOOD_STATUS: rdata_q <= rail_good_status_w;
                `FSS_ADDR_OUTPUT_ENABLE_REG: rdata_q <= output_enable_reg_q;
                `FSS_ADDR_SYSTEM_CONTROL_TWO: rdata_q <= system_control_two_q;
                `FSS_ADDR_TGT0: rdata_q <= tgt_q[0];
                `FSS_ADDR_TGT1: rdata_q <= tgt_q[1];
                `FSS_ADDR_TGT2: rdata_q <= tgt_q[2];
                `FSS_ADDR_TGT3: rdata_q <= tgt_q[3];
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reg_en_o = en_q;
    assign wake_o = wake_q;
    assign irq_n_o = irq_n_q;
    assign rail_ok_output_o = rail_ok_q;
    assign reset_output_n_o = rst_n_q;
    assign powerdown_state_o = pdn_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_output_enable_reg_po_fall: assert property (po_fall && !cmd_clear |=> output_enable_reg_q == 8'h00)
        else $error("enable register not cleared on request fall");
    a_fault_off: assert property (fault_evt |=> en_q == 7'h00 && !wake_q && output_enable_reg_q == 8'h00 && pdn_q)
        else $error("fault did not shut rails down");
    a_fault_irq: assert property (fault_evt |=> !irq_n_q ##1 !irq_n_q)
        else $error("fault did not latch interrupt");
    a_keep_clear: assert property (cmd_clear |=> ka_map == 7'h00)
        else $error("keep-alive survived shutdown");
    a_sw_mode: assert property (output_enable_reg_q[7] && !inhibit |=> en_q == ($past(output_enable_reg_q[6:0]) | $past(ka_map)))
        else $error("software mode enable mismatch");
    a_none_enabled: assert property (en_q == 7'h00 |=> !rail_ok_q)
        else $error("rail ok high with no rail enabled");
    a_hard_rst: assert property (hr_evt |=> !reset_output_n_o [*3])
        else $error("reset output not low after hard reset");
    a_uv_warn: assert property (uvw_s && sensed |=> fws_q[4] && !irq_n_q)
        else $error("undervoltage warning not reported");
    a_th_warn: assert property (thw_s && sensed |=> fws_q[6] && !irq_n_q)
        else $error("thermal warning not reported");
    a_slew_low: assert property (|(slew_s & ~slew_ok) |=> !rail_ok_q && rail_good_status_w == $past(rail_good_status_w))
        else $error("slew did not pull rail ok low");
    a_fault_keep: assert property ($past(run_w) && !$past(fault_evt) && !$past(hr_evt) |-> run_w)
        else $error("state left run without cause");

    c_fault: cover property (fault_evt ##[1:20] clr_cmd);
    c_sw_mode: cover property (output_enable_reg_q[7] && en_q != 7'h00);
    c_rst_rel: cover property ($rose(reset_output_n_o));
    c_pg_up: cover property ($rose(rail_ok_output_o));
endmodule

//--- bench/fss_host.sv
`timescale 1ns/1ps
module fss_host import fss_pkg::*; (
    // clock
    input wire logic clk_i,
    // register port towards the supervisor
    output logic reg_wr_o,
    output logic reg_sub_ack_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_sub_ack_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // sub-address acknowledged first, data commits one edge later
    task automatic wr(input fss_byte_t a, input fss_byte_t d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_sub_ack_o <= 1'b1;
        @(posedge clk_i);
        reg_sub_ack_o <= 1'b0;
        reg_wr_o <= 1'b1;
        reg_wdata_o <= d;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        // released data must not linger as a stale match
        reg_wdata_o <= ~d;
    endtask

    // read data is registered one edge after the address
    task automatic rd(input fss_byte_t a, output fss_byte_t d);
        @(posedge clk_i);
        reg_addr_o <= a;
        @(posedge clk_i);
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
`include "fss_defs.svh"
module tb;
    import fss_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_wr, reg_sub_ack;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic power_on_request = 1'b0;
    logic [6:0] en_pin = 7'h00;
    logic hard_reset = 1'b0;
    logic [7:0] rail_good_raw = 8'hFF;
    logic [3:0] slew_active = 4'h0;
    logic vin_warn = 1'b0;
    logic vin_fault = 1'b0;
    logic temp_warn = 1'b0;
    logic temp_fault = 1'b0;
    logic [6:0] reg_en;
    logic wake, irq_n, rail_ok, rst_out_n, powerdown_state;
    fss_byte_t d;
    int err_total = 0;
    int checked = 0;

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    fss_host i_host (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_sub_ack_o(reg_sub_ack), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

    // short counts keep the run small; expectations below follow these values
    fss_supervisor #(.P_PGD_CYC(50), .P_TO_CYC(300), .P_INH_CYC(400)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr), .reg_sub_ack_i(reg_sub_ack),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .power_on_request_i(power_on_request), .en_pin_i(en_pin), .hard_reset_i(hard_reset),
        .rail_good_raw_i(rail_good_raw), .slew_active_i(slew_active), .vin_warn_i(vin_warn),
        .vin_fault_i(vin_fault), .temp_warn_i(temp_warn), .temp_fault_i(temp_fault), .reg_en_o(reg_en),
        .wake_o(wake), .irq_n_o(irq_n), .rail_ok_output_o(rail_ok), .reset_output_n_o(rst_out_n),
        .powerdown_state_o(powerdown_state));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic test_done();
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // a hang anywhere counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        chk(rst_out_n, 0);
        @(posedge clk_i) rst_n_i <= 1'b1;
        cyc(380);
        chk(rst_out_n, 0);
        chk(rail_ok, 0);
        i_host.rd(`FSS_ADDR_RAIL_GOOD_STATUS, d);
        chk(d, 8'h00);
        cyc(60);
        chk(rst_out_n, 1);
        // software control ignores the pins, otherwise bits and pins combine
        @(posedge clk_i);
        power_on_request <= 1'b1;
        en_pin <= 7'h7A;
        i_host.wr(`FSS_ADDR_OUTPUT_ENABLE_REG, 8'h85);
        cyc(3);
        chk(reg_en, 7'h05);
        i_host.wr(`FSS_ADDR_OUTPUT_ENABLE_REG, 8'h05);
        cyc(3);
        chk(reg_en, 7'h7F);
        @(posedge clk_i) en_pin <= 7'h00;
        i_host.wr(`FSS_ADDR_OUTPUT_ENABLE_REG, 8'h81);
        cyc(3);
        chk(rail_ok, 1);
        i_host.rd(`FSS_ADDR_RAIL_GOOD_STATUS, d);
        chk(d, 8'h03);
        // dip on the first step-down rail
        @(posedge clk_i) rail_good_raw <= 8'hFD;
        cyc(495);
        chk(rail_ok, 1);
        cyc(15);
        chk(rail_ok, 0);
        i_host.rd(`FSS_ADDR_RAIL_GOOD_STATUS, d);
        chk(d, 8'h01);
        @(posedge clk_i) rail_good_raw <= 8'hFF;
        cyc(45);
        chk(rail_ok, 0);
        cyc(15);
        chk(rail_ok, 1);
        // slew drops the pin only, unless its target says otherwise
        @(posedge clk_i) slew_active <= 4'h1;
        cyc(5);
        chk(rail_ok, 0);
        i_host.rd(`FSS_ADDR_RAIL_GOOD_STATUS, d);
        chk(d, 8'h03);
        i_host.wr(`FSS_ADDR_TGT0, 8'h20);
        cyc(3);
        chk(rail_ok, 1);
        @(posedge clk_i) slew_active <= 4'h0;
        // keep-alive survives a normal shutdown
        i_host.wr(`FSS_ADDR_TGT1, 8'h40);
        @(posedge clk_i) power_on_request <= 1'b0;
        cyc(5);
        chk(reg_en, 7'h02);
        i_host.rd(`FSS_ADDR_OUTPUT_ENABLE_REG, d);
        chk(d, 8'h00);
        i_host.wr(`FSS_ADDR_TGT1, 8'h00);
        cyc(3);
        chk(reg_en, 7'h00);
        chk(rail_ok, 0);
        i_host.rd(`FSS_ADDR_RAIL_GOOD_STATUS, d);
        chk(d, 8'h00);
        // warnings
        @(posedge clk_i) power_on_request <= 1'b1;
        i_host.wr(`FSS_ADDR_OUTPUT_ENABLE_REG, 8'h81);
        @(posedge clk_i) vin_warn <= 1'b1;
        cyc(5);
        chk(irq_n, 0);
        @(posedge clk_i) vin_warn <= 1'b0;
        cyc(5);
        chk(irq_n, 0);
        i_host.rd(`FSS_ADDR_FWSTAT, d);
        chk(d, 8'h10);
        i_host.wr(`FSS_ADDR_CLRIRQ, 8'hFF);
        cyc(3);
        chk(irq_n, 1);
        i_host.rd(`FSS_ADDR_FWSTAT, d);
        chk(d, 8'h00);
        @(posedge clk_i) temp_warn <= 1'b1;
        cyc(5);
        i_host.wr(`FSS_ADDR_CLRIRQ, 8'h00);
        cyc(3);
        chk(irq_n, 0);
        i_host.rd(`FSS_ADDR_FWSTAT, d);
        chk(d, 8'h40);
        @(posedge clk_i) temp_warn <= 1'b0;
        cyc(5);
        chk(irq_n, 1);
        // masked rail timeout is reported but shuts nothing down
        i_host.wr(`FSS_ADDR_SYSTEM_CONTROL_TWO, 8'h80);
        @(posedge clk_i) rail_good_raw <= 8'hFD;
        cyc(830);
        chk(powerdown_state, 0);
        i_host.rd(`FSS_ADDR_FWSTAT, d);
        chk(d, 8'h08);
        chk(irq_n, 0);
        @(posedge clk_i) rail_good_raw <= 8'hFF;
        cyc(60);
        i_host.wr(`FSS_ADDR_CLRIRQ, 8'h00);
        cyc(3);
        chk(irq_n, 1);
        i_host.wr(`FSS_ADDR_SYSTEM_CONTROL_TWO, 8'h00);
        // thermal fault shutdown and recovery
        @(posedge clk_i) temp_fault <= 1'b1;
        cyc(5);
        chk(powerdown_state, 1);
        chk({reg_en, wake}, 8'h00);
        chk(irq_n, 0);
        i_host.rd(`FSS_ADDR_OUTPUT_ENABLE_REG, d);
        chk(d, 8'h00);
        @(posedge clk_i);
        temp_fault <= 1'b0;
        en_pin <= 7'h04;
        i_host.wr(`FSS_ADDR_CLRIRQ, 8'h00);
        cyc(3);
        chk(irq_n, 1);
        chk(reg_en, 7'h00);
        i_host.rd(`FSS_ADDR_FWSTAT, d);
        chk(d, 8'h80);
        cyc(420);
        chk(powerdown_state, 0);
        chk(wake, 1);
        chk(reg_en, 7'h04);
        i_host.rd(`FSS_ADDR_FWSTAT, d);
        chk(d, 8'h00);
        // hard reset drops the reset output and the keep-alive bits
        i_host.wr(`FSS_ADDR_TGT0, 8'h40);
        @(posedge clk_i) hard_reset <= 1'b1;
        @(posedge clk_i) hard_reset <= 1'b0;
        cyc(3);
        chk(rst_out_n, 0);
        i_host.rd(`FSS_ADDR_TGT0, d);
        chk(d, 8'h00);
        test_done();
    end
endmodule
